// *** sim/lcc_charge_ctrl_monitor.sv ***
// Concurrent checks on the charge control block's pins
`timescale 1ns/1ps
module lcc_charge_ctrl_monitor
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Watched inputs
  input wire logic             charge_en_n,
  input wire logic             vin_valid,
  input wire logic             vin_over,
  input wire logic             sys_above_exit,
  input wire logic             bat_above_uvlo,
  // Watched outputs
  input wire logic             charge_switch_on,
  input wire logic             input_switch_on,
  input wire logic             sys_from_battery,
  input wire logic             supplement_mode,
  input wire logic [CUR_W-1:0] charge_current,
  input wire logic             host_alert_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // off_cnt saturates so a long idle spell cannot wrap round; low_cnt wraps
  logic [15:0] off_cnt;
  logic [15:0] low_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || charge_switch_on)
      off_cnt <= 16'h0000;
    else if (off_cnt != 16'hffff)
      off_cnt <= off_cnt + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || host_alert_n)
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 16'h0001;
  end

  a_pin_blocks :
    assert property (charge_en_n [*6] |-> !charge_switch_on)
    else $error("charge switch on with pin high");
  a_no_source :
    assert property (!vin_valid [*6] |-> !charge_switch_on)
    else $error("charge switch on without source");
  a_ovp_cut :
    assert property (vin_over [*4] |-> !input_switch_on)
    else $error("input switch on during over-voltage");
  a_ovp_alert :
    assert property (!vin_over ##1 vin_over [*4] |-> ##[0:4] !host_alert_n)
    else $error("no alert on over-voltage");
  // One pulse is 2560 cycles of aclk, a few of slack for the sampling
  a_alert_width :
    assert property ($rose(host_alert_n) |->
                     low_cnt >= 16'h09f6 && low_cnt <= 16'h0a0a)
    else $error("alert pulse width wrong");
  a_input_back :
    assert property ((vin_valid && !vin_over) [*4] |-> input_switch_on)
    else $error("input switch not restored");
  a_batt_path :
    assert property ((!vin_valid && bat_above_uvlo) [*4] |-> sys_from_battery)
    else $error("system rail not on battery");
  a_supp_holds :
    assert property (!sys_above_exit [*4] ##0 supplement_mode
                     |=> supplement_mode)
    else $error("supplement left early");
  // A new current must follow nearly a millisecond (19900 cycles of aclk) with the switch off
  a_pause_first :
    assert property ($changed(charge_current) && charge_current != '0
                     |-> off_cnt >= 16'h4dbc)
    else $error("current applied without pause");

  c_supp : cover property ($rose(supplement_mode));
  c_alert : cover property ($fell(host_alert_n));
  c_charge : cover property ($rose(charge_switch_on));
endmodule : lcc_charge_ctrl_monitor

bind lcc_charge_ctrl lcc_charge_ctrl_monitor lcc_charge_ctrl_monitor_i (
  .aclk, .aresetn, .charge_en_n, .vin_valid, .vin_over, .sys_above_exit,
  .bat_above_uvlo, .charge_switch_on, .input_switch_on, .sys_from_battery,
  .supplement_mode, .charge_current, .host_alert_n
);

// *** sim/lcc_charge_ctrl_test.sv ***
// Self-checking bench for the charge control block
`timescale 1ns/1ps
module lcc_charge_ctrl_test;
  import lcc_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn, clk_en, s_axi_awvalid, s_axi_wvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid, load_heavy;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, fast, pre;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd, ctrl;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  logic              charge_en_n, vin_valid, vin_over, bat_below_precharge;
  logic              cv_loop_active, at_term_current, thermal_reg_active;
  logic              temp_warm, input_hold_active, system_hold_active;
  logic              sys_below_enter, sys_above_exit, bat_above_uvlo;
  logic              ref_clk, charge_switch_on, input_switch_on;
  logic              sys_from_battery, supplement_mode, input_hold_enable;
  logic              system_hold_enable, host_alert_n;
  logic [CUR_W-1:0]  charge_current;
  logic [SEL_W-1:0]  input_hold_sel, sel;
  logic [15:0]       vin_mv;
  int                n_fail = 0, checks = 0, cyc = 0, n;
  integer            seed = 32'h761aee3d;

  lcc_charge_ctrl lcc_charge_ctrl_i (.*);
  lcc_source_model lcc_source_model_i (.*);

  always #25 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Response is awaited without a cycle budget; the run limit ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic poll(input logic [31:0] m, v, input int lim);
    int t0;
    t0 = cyc;
    axi_rd(REG_STATUS);
    while ((rd & m) !== v && cyc - t0 < lim)
      axi_rd(REG_STATUS);
    n = cyc - t0;
  endtask : poll

  task automatic inhibit(input int k, input logic on);
    case (k)
      0: thermal_reg_active <= on;
      1: vin_mv <= on ? 16'(HOLD_BASE_MV + HOLD_STEP_MV * sel - 50) : 16'h1388;
      2: load_heavy <= on;
      default: sys_below_enter <= on;
    endcase
  endtask : inhibit

  function automatic logic [2:0] exp_state(input logic pin_n, off, low);
    if (pin_n || off)
      return 3'h0;
    return low ? 3'h1 : 3'h2;
  endfunction : exp_state

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata, aresetn, bat_below_precharge,
     cv_loop_active, at_term_current, thermal_reg_active, temp_warm,
     sys_below_enter, sys_above_exit, load_heavy} = '0;
    {clk_en, charge_en_n, bat_above_uvlo, s_axi_wstrb} = 7'h7f;
    vin_mv = 16'h1388;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("hold_rst", 32'h0, 32'(input_hold_enable));
    axi_rd(REG_CTRL);
    chk("ctrl_rst", 32'h0, rd);
    axi_rd(8'h14);
    chk("bad_resp", 32'(RESP_SLVERR), 32'(rs));
    sel = SEL_W'($unsigned($random(seed)) % 6 + 2);
    fast = 8'($random(seed)) | 8'h01;
    pre = (fast ^ 8'h55) | 8'h01;
    axi_wr(REG_ICHG, {16'h0, pre, fast});
    ctrl = 32'h1 | (32'h1 << CTRL_INHOLD) | (32'(sel) << CTRL_SEL_LO);
    axi_wr(REG_CTRL, ctrl | (32'h1 << CTRL_TRACK));
    chk("hold_en", 32'h1, 32'(input_hold_enable));
    chk("hold_sel", 32'(sel), 32'(input_hold_sel));
    chk("sys_trk", 32'h0, 32'(system_hold_enable));
    axi_wr(REG_CTRL, ctrl);
    chk("sys_en", 32'h1, 32'(system_hold_enable));
    bat_below_precharge <= 1'b1;
    for (int i = 3; i >= 0; i--)
    begin
      charge_en_n <= i[0];
      axi_wr(REG_CTRL, ctrl & ~32'h1 | 32'(i[1]));
      repeat (8) @(posedge aclk);
      axi_rd(REG_STATUS);
      chk("enable", 32'(exp_state(i[0], i[1], 1'b1)), 32'(rd[2:0]));
      chk("sw_pin", 32'h0, 32'(charge_switch_on));
    end
    chk("pausing", 32'h1, 32'(rd[7]));
    poll(32'h100, 32'h100, 25000);
    chk("pre_wait", 32'h1, 32'(n > 18000 && n < 21000));
    chk("pre_cur", 32'(pre), 32'(charge_current));
    bat_below_precharge <= 1'b0;
    poll(32'h7, 32'h2, 50);
    chk("fast", 32'h2, 32'(rd[2:0]));
    poll(32'h100, 32'h100, 25000);
    chk("fast_wait", 32'h1, 32'(n > 18000));
    chk("fast_cur", 32'(fast), 32'(charge_current));
    // Next inhibitor goes on before the last comes off: no gap to terminate
    for (int k = 0; k < 4; k++)
    begin
      inhibit(k, 1'b1);
      repeat (6) @(posedge aclk);
      if (k == 0)
        {cv_loop_active, at_term_current} <= 2'h3;
      else
        inhibit(k - 1, 1'b0);
      repeat (40) @(posedge aclk);
      axi_rd(REG_STATUS);
      chk("no_term", 32'h2, 32'(rd[2:0]));
      if (k == 1 || k == 2)
      begin
        chk("hold_stat", 32'h1, 32'(rd[3 + k]));
        axi_rd(REG_FLAGS);
        chk("hold_flag", 32'h1, 32'(rd[k]));
      end
    end
    sys_below_enter <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("supp_kept", 32'h1, 32'(supplement_mode));
    sys_above_exit <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("supp_left", 32'h0, 32'(supplement_mode));
    poll(32'h7, 32'h3, 50);
    chk("term", 32'h3, 32'(rd[2:0]));
    chk("term_sw", 32'h0, 32'(charge_switch_on));
    {cv_loop_active, at_term_current, sys_above_exit} <= 3'h0;
    vin_mv <= 16'(OVP_MV);
    repeat (8) @(posedge aclk);
    chk("ovp_edge", 32'h1, 32'(input_switch_on));
    vin_mv <= 16'(OVP_MV + 1);
    for (n = 0; host_alert_n !== 1'b0 && n < 20; n++)
      @(posedge aclk);
    chk("ovp_in_sw", 32'h0, 32'(input_switch_on));
    axi_rd(REG_STATUS);
    chk("ovp_stat", 32'h1, 32'(rd[3]));
    repeat (2)
    begin
      axi_rd(REG_FLAGS);
      chk("ovp_flag", 32'h1, 32'(rd[FLG_OVP]));
    end
    for (n = 0; host_alert_n !== 1'b1 && n < 3000; n++)
      @(posedge aclk);
    chk("alert_len", 32'h1, 32'(n > 2500 && n < 2570));
    vin_mv <= 16'h1388;
    repeat (8) @(posedge aclk);
    axi_rd(REG_STATUS);
    chk("ovp_gone", 32'h0, 32'(rd[3]));
    chk("in_sw_back", 32'h1, 32'(input_switch_on));
    for (int j = 1; j >= 0; j--)
    begin
      axi_rd(REG_FLAGS);
      chk("ovp_read", 32'(j), 32'(rd[FLG_OVP]));
    end
    vin_mv <= 16'h0000;
    repeat (8) @(posedge aclk);
    chk("on_batt", 32'h1, 32'(sys_from_battery));
    bat_above_uvlo <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("batt_low", 32'h0, 32'(sys_from_battery));
    bat_above_uvlo <= 1'b1;
    axi_wr(REG_TIMER, 32'h4);
    {bat_below_precharge, vin_mv} <= {1'b1, 16'h1388};
    poll(32'h7, 32'h4, 60000);
    chk("safety", 32'h4, 32'(rd[2:0]));
    chk("quarter", 32'h1, 32'(n < 45000));
    chk("safe_sw", 32'h0, 32'(charge_switch_on));
    chk("safe_alert", 32'h0, 32'(host_alert_n));
    axi_rd(REG_FLAGS);
    chk("safe_flag", 32'h1, 32'(rd[FLG_SAFE]));
    tally_and_finish();
  end
endmodule : lcc_charge_ctrl_test

// *** sim/lcc_source_model.sv ***
// Adapter, system rail and reference clock seen by the charger
`timescale 1ns/1ps
module lcc_source_model
  import lcc_pkg::*;
(
  // Bench settings
  input wire logic [15:0]      vin_mv,
  input wire logic             load_heavy,
  // Loop controls from the charger
  input wire logic             input_hold_enable,
  input wire logic [SEL_W-1:0] input_hold_sel,
  input wire logic             system_hold_enable,
  // Comparators and clock
  output logic                 ref_clk,
  output logic                 vin_valid,
  output logic                 vin_over,
  output logic                 input_hold_active,
  output logic                 system_hold_active
);
  localparam int VIN_MIN_MV = 3600;

  // Offset start keeps its edges clear of aclk edges
  initial
  begin
    ref_clk = 1'b0;
    #13;
    forever #(REF_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  assign vin_valid = int'(vin_mv) >= VIN_MIN_MV;
  assign vin_over = int'(vin_mv) > OVP_MV;
  assign input_hold_active = input_hold_enable && int'(vin_mv) <=
    HOLD_BASE_MV + HOLD_STEP_MV * int'(input_hold_sel);
  assign system_hold_active = system_hold_enable && load_heavy;
endmodule : lcc_source_model

// *** verilog/lcc_charge_ctrl.sv ***
// Single-cell charger control with AXI4-Lite register access
// Function
// - Charge only with pin low and off bit 0
// - Enable pin high keeps charge switch off
// - Precharge current; timer limit one quarter
// - Reaching threshold moves to fast charge
// - Terminate at term current under CV only
// - No termination in hold, thermal, warm
// - No termination in supplement mode
// - Pause about 1 ms on current change
// - Input hold off at reset, 4.2-4.9 V
// - System hold off under battery tracking
// - Hold loops set status and flags
// - Doubling extends timer during hold loops
// - Supplement enter/exit with two offsets
// - Over-voltage: input off, alert, flag, status
// - Over-voltage status clears on its own
// - Over-voltage flag cleared only by later read
// - Over-voltage trip is 5.5 V
// - No input, battery above UVLO: system rail from battery
// - Safety expiry: stop, alert, fault flag
// - Doubling halves timer rate in other loops
`timescale 1ns/1ps
module lcc_charge_ctrl
  import lcc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // AXI4-Lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins and analog comparators, asynchronous
  input  wire logic              charge_en_n,
  input  wire logic              vin_valid,
  input  wire logic              vin_over,
  input  wire logic              bat_below_precharge,
  input  wire logic              cv_loop_active,
  input  wire logic              at_term_current,
  input  wire logic              thermal_reg_active,
  input  wire logic              temp_warm,
  input  wire logic              input_hold_active,
  input  wire logic              system_hold_active,
  input  wire logic              sys_below_enter,
  input  wire logic              sys_above_exit,
  input  wire logic              bat_above_uvlo,
  input  wire logic              ref_clk,
  // Power path controls
  output logic                   charge_switch_on,
  output logic                   input_switch_on,
  output logic                   sys_from_battery,
  output logic                   supplement_mode,
  output logic [CUR_W-1:0]       charge_current,
  output logic                   input_hold_enable,
  output logic [SEL_W-1:0]       input_hold_sel,
  output logic                   system_hold_enable,
  output logic                   host_alert_n
);

  typedef struct packed {
    logic [PIN_W-1:0]  sync1;
    logic [PIN_W-1:0]  sync2;
    logic              ref_prev;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              off_bit;
    logic              tdbl;
    logic              inhold_en;
    logic              track;
    logic [SEL_W-1:0]  sel;
    logic [CUR_W-1:0]  fast_cur;
    logic [CUR_W-1:0]  pre_cur;
    logic [TMR_W-1:0]  limit;
    lcc_state_t        state;
    logic [CUR_W-1:0]  applied;
    logic              pausing;
    logic [TICK_W-1:0] pause_cnt;
    logic [TICK_W-1:0] ms_cnt;
    logic              half;
    logic [TMR_W-1:0]  safety;
    logic              alerting;
    logic [TICK_W-1:0] alert_cnt;
    logic              ovp_prev;
    logic              supp;
    logic [FLG_W-1:0]  flags;
    logic              chg_sw;
    logic              in_sw;
    logic              from_bat;
  } lcc_regs_t;

  lcc_regs_t s;
  lcc_regs_t next_s;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin;
  logic             ref_rise;
  logic             ovp;
  logic             in_hold;
  logic             sys_hold;
  logic             may_charge;
  logic             slow;
  logic             term_ok;
  logic [CUR_W-1:0] want;
  logic [TMR_W-1:0] phase_limit;
  logic             fault_evt;
  logic             do_wr;
  logic             do_rd;
  logic [FLG_W-1:0] flag_set;
  logic [FLG_W-1:0] flag_clr;
  logic [31:0]      status_word;

  assign pin_raw = {ref_clk, bat_above_uvlo, sys_above_exit,
                    sys_below_enter, system_hold_active,
                    input_hold_active, temp_warm, thermal_reg_active,
                    at_term_current, cv_loop_active, bat_below_precharge,
                    vin_over, vin_valid, charge_en_n};
  assign pin     = s.sync2;

  always_comb
  begin
    next_s = s;

    // Two-stage pin synchronisers; only sync2 feeds logic
    next_s.sync1    = pin_raw;
    next_s.sync2    = s.sync1;
    next_s.ref_prev = pin[P_REF];
    ref_rise        = pin[P_REF] && !s.ref_prev;

    // Comparator already trips at the fixed over-voltage point
    ovp      = pin[P_OVER];
    in_hold  = pin[P_INH] && s.inhold_en;
    sys_hold = pin[P_SYSH] && !s.track;

    // All four conditions needed; anything else keeps charging off
    may_charge = !pin[P_CE_N] && !s.off_bit
                 && pin[P_VINOK] && !ovp;

    // Supplement hysteresis between two offsets
    if (pin[P_SLO])
      next_s.supp = 1'b1;
    else if (pin[P_SHI])
      next_s.supp = 1'b0;

    term_ok = pin[P_CV] && pin[P_TERM]
              && !in_hold && !sys_hold && !pin[P_THERM]
              && !pin[P_WARM]
              && !s.supp;

    // Warm region halves the requested current
    want = (s.state == ST_PRE) ? s.pre_cur : s.fast_cur;
    if (pin[P_WARM])
      want = want >> 1;

    slow = s.tdbl && (in_hold || sys_hold
                      || pin[P_THERM] || pin[P_WARM]);
    phase_limit = (s.state == ST_PRE) ? (s.limit >> 2) : s.limit;

    fault_evt = 1'b0;
    flag_set  = '0;

    // Millisecond tick from the reference clock drives the timer
    if (ref_rise)
    begin
      if (s.ms_cnt == TICK_W'(PAUSE_TICKS - 1))
      begin
        next_s.ms_cnt = '0;
        if (s.state == ST_PRE || s.state == ST_FAST)
        begin
          next_s.half = !s.half;
          if (!slow || s.half)
            next_s.safety = s.safety + 1'b1;
        end
      end
      else
        next_s.ms_cnt = s.ms_cnt + 1'b1;
    end

    // Current change: hold charging off, then apply
    if (s.pausing)
    begin
      if (ref_rise)
      begin
        if (s.pause_cnt == TICK_W'(PAUSE_TICKS - 1))
        begin
          next_s.pausing = 1'b0;
          next_s.applied = want;
        end
        else
          next_s.pause_cnt = s.pause_cnt + 1'b1;
      end
    end
    else if (want != s.applied &&
             (s.state == ST_PRE || s.state == ST_FAST))
    begin
      next_s.pausing   = 1'b1;
      next_s.pause_cnt = '0;
    end

    case (s.state)
      ST_IDLE:
      begin
        next_s.safety = '0;
        next_s.half   = 1'b0;
        if (may_charge)
          next_s.state = pin[P_BLOW] ? ST_PRE : ST_FAST;
      end
      ST_PRE:
      begin
        if (!may_charge)
          next_s.state = ST_IDLE;
        else if (s.safety >= phase_limit)
          fault_evt = 1'b1;
        else if (!pin[P_BLOW])
          next_s.state = ST_FAST;
      end
      ST_FAST:
      begin
        if (!may_charge)
          next_s.state = ST_IDLE;
        else if (s.safety >= phase_limit)
          fault_evt = 1'b1;
        else if (term_ok && !s.pausing)
          next_s.state = ST_DONE;
      end
      ST_DONE:
      begin
        if (!may_charge)
          next_s.state = ST_IDLE;
      end
      ST_FAULT:
      begin
        // Only the pin or input power releases the fault
        if (pin[P_CE_N] || !pin[P_VINOK])
          next_s.state = ST_IDLE;
      end
      default:
        next_s.state = ST_IDLE;
    endcase

    if (fault_evt)
    begin
      next_s.state       = ST_FAULT;
      flag_set[FLG_SAFE] = 1'b1;
    end

    // Over-voltage edge gives one alert pulse
    next_s.ovp_prev = ovp;
    if (ovp && !s.ovp_prev)
      fault_evt = 1'b1;
    flag_set[FLG_OVP]  = ovp;
    flag_set[FLG_INH]  = in_hold;
    flag_set[FLG_SYSH] = sys_hold;

    if (fault_evt)
    begin
      next_s.alerting  = 1'b1;
      next_s.alert_cnt = '0;
    end
    else if (s.alerting && ref_rise)
    begin
      if (s.alert_cnt == TICK_W'(ALERT_TICKS - 1))
        next_s.alerting = 1'b0;
      else
        next_s.alert_cnt = s.alert_cnt + 1'b1;
    end

    next_s.in_sw    = pin[P_VINOK] && !ovp;
    next_s.from_bat = !pin[P_VINOK] && pin[P_UVOK];
    next_s.chg_sw   = may_charge && !next_s.pausing &&
                      (next_s.state == ST_PRE ||
                       next_s.state == ST_FAST);

    status_word = '0;
    status_word[2:0] = s.state;
    status_word[3]   = ovp;
    status_word[4]   = in_hold;
    status_word[5]   = sys_hold;
    status_word[6]   = s.supp;
    status_word[7]   = s.pausing;
    status_word[8]   = s.chg_sw;
    status_word[9]   = s.in_sw;
    status_word[10]  = s.from_bat;

    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && !s.aw_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got && !s.bvalid)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    do_wr = s.aw_got && s.w_got;
    if (do_wr)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case (s.awaddr)
        REG_CTRL:
        begin
          if (s.wstrb[0])
          begin
            next_s.off_bit   = s.wdata[CTRL_OFF];
            next_s.tdbl      = s.wdata[CTRL_TDBL];
            next_s.inhold_en = s.wdata[CTRL_INHOLD];
            next_s.track     = s.wdata[CTRL_TRACK];
            next_s.sel       = s.wdata[CTRL_SEL_LO +: SEL_W];
          end
        end
        REG_ICHG:
        begin
          if (s.wstrb[0])
            next_s.fast_cur = s.wdata[ICHG_FAST_LO +: CUR_W];
          if (s.wstrb[1])
            next_s.pre_cur = s.wdata[ICHG_PRE_LO +: CUR_W];
        end
        REG_TIMER:
        begin
          if (s.wstrb[0])
            next_s.limit[7:0] = s.wdata[7:0];
          if (s.wstrb[1])
            next_s.limit[15:8] = s.wdata[15:8];
          if (s.wstrb[2])
            next_s.limit[TMR_W-1:16] = s.wdata[TMR_W-1:16];
          // New duration restarts a running timer
          next_s.safety = '0;
          next_s.half   = 1'b0;
        end
        REG_STATUS, REG_FLAGS:
          ;
        default:
          next_s.bresp = RESP_SLVERR;
      endcase
    end
    else if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // AXI4-Lite read; a flag read clears what it returned, except the over-voltage flag while over-voltage lasts
    flag_clr = '0;
    do_rd    = s_axi_arvalid && !s.rvalid;
    if (do_rd)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      case (s_axi_araddr)
        REG_CTRL:
        begin
          next_s.rdata[CTRL_OFF]    = s.off_bit;
          next_s.rdata[CTRL_TDBL]   = s.tdbl;
          next_s.rdata[CTRL_INHOLD] = s.inhold_en;
          next_s.rdata[CTRL_TRACK]  = s.track;
          next_s.rdata[CTRL_SEL_LO +: SEL_W] = s.sel;
        end
        REG_ICHG:
        begin
          next_s.rdata[ICHG_FAST_LO +: CUR_W] = s.fast_cur;
          next_s.rdata[ICHG_PRE_LO +: CUR_W]  = s.pre_cur;
        end
        REG_TIMER:
          next_s.rdata[TMR_W-1:0] = s.limit;
        REG_STATUS:
          next_s.rdata = status_word;
        REG_FLAGS:
        begin
          next_s.rdata[FLG_W-1:0] = s.flags;
          flag_clr = s.flags;
          if (ovp)
            flag_clr[FLG_OVP] = 1'b0;
        end
        default:
          next_s.rresp = RESP_SLVERR;
      endcase
    end
    else if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;

    // A new event beats a clear in the same cycle
    next_s.flags = (s.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s           <= '0;
      s.state     <= ST_IDLE;
      s.fast_cur  <= FAST_RST;
      s.pre_cur   <= PRE_RST;
      s.limit     <= LIMIT_RST;
      s.inhold_en <= 1'b0;
    end
    else if (clk_en)
      s <= next_s;
  end

  assign s_axi_awready      = !s.aw_got && !s.bvalid;
  assign s_axi_wready       = !s.w_got && !s.bvalid;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = !s.rvalid;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign charge_switch_on   = s.chg_sw;
  assign input_switch_on    = s.in_sw;
  assign sys_from_battery   = s.from_bat;
  assign supplement_mode    = s.supp;
  assign charge_current     = s.applied;
  assign input_hold_enable  = s.inhold_en;
  assign input_hold_sel     = s.sel;
  assign system_hold_enable = !s.track;
  assign host_alert_n       = !s.alerting;

endmodule : lcc_charge_ctrl

// *** verilog/lcc_pkg.sv ***
// Constants and types for the charge control block
package lcc_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ICHG   = 8'h04;
  localparam logic [7:0] REG_TIMER  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_FLAGS  = 8'h10;

  // Control, charge current and timer register fields and widths
  localparam int CTRL_OFF      = 0;
  localparam int CTRL_TDBL     = 1;
  localparam int CTRL_INHOLD   = 2;
  localparam int CTRL_TRACK    = 3;
  localparam int CTRL_SEL_LO   = 4;
  localparam int SEL_W         = 3;
  localparam int ICHG_FAST_LO  = 0;
  localparam int ICHG_PRE_LO   = 8;
  localparam int CUR_W         = 8;
  localparam int TMR_W         = 20;

  // Reset values
  localparam logic [7:0]       FAST_RST  = 8'h40;
  localparam logic [7:0]       PRE_RST   = 8'h08;
  localparam logic [TMR_W-1:0] LIMIT_RST = 20'h2bf20;

  // Flag bits
  localparam int FLG_OVP  = 0;
  localparam int FLG_INH  = 1;
  localparam int FLG_SYSH = 2;
  localparam int FLG_SAFE = 3;
  localparam int FLG_W    = 4;

  // Pin vector positions
  localparam int P_CE_N  = 0;
  localparam int P_VINOK = 1;
  localparam int P_OVER  = 2;
  localparam int P_BLOW  = 3;
  localparam int P_CV    = 4;
  localparam int P_TERM  = 5;
  localparam int P_THERM = 6;
  localparam int P_WARM  = 7;
  localparam int P_INH   = 8;
  localparam int P_SYSH  = 9;
  localparam int P_SLO   = 10;
  localparam int P_SHI   = 11;
  localparam int P_UVOK  = 12;
  localparam int P_REF   = 13;
  localparam int PIN_W   = 14;

  // Voltages in mV: input hold base/step, over-voltage trip point
  localparam int HOLD_BASE_MV = 4200;
  localparam int HOLD_STEP_MV = 100;
  localparam int OVP_MV       = 5500;

  // Times; the reference clock period sets the tick counts
  localparam int REF_PERIOD_NS = 400;
  localparam int PAUSE_US      = 1000;
  localparam int ALERT_US      = 128;
  localparam int PAUSE_TICKS   = (PAUSE_US * 1000) / REF_PERIOD_NS;
  localparam int ALERT_TICKS   = (ALERT_US * 1000) / REF_PERIOD_NS;
  localparam int TICK_W        = 12;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_FAST  = 3'b010,
    ST_DONE  = 3'b011,
    ST_FAULT = 3'b100
  } lcc_state_t;

endpackage : lcc_pkg
